// File: core/qpm_params.svh
`ifndef QPM_PARAMS_SVH
`define QPM_PARAMS_SVH
// Behaviour
// - Four egress queues, each frame gets one
// - Eight-entry writable tag-priority queue table
// - Tag table defaults 1,2/0,3/4,5/6,7 to 0..3
// - Tag priority is 3-bit field, 0 to 7
// - 64-entry writable code point queue table
// - Code point defaults 0-7:1, 8-23:0, 24-31:1, 32-47:2, 48-63:3
// - Code point taken from old type-of-service byte
// - Strict scheme: queue 3 highest, 0 lowest
// - Per-port trust mode, four options, tag default
// - Per-port default priority for untagged frames
// - Weighted mode serves 8:4:2:1 per round
// - Strict mode serves nonempty higher queue first

// ----------------------------------------
// Sizes
// ----------------------------------------
`define QPM_NUM_QUEUES   4
`define QPM_NUM_COS      8
`define QPM_NUM_DSCP     64
`define QPM_MAX_PORTS    64

// ----------------------------------------
// Register map (word addresses, 8-bit)
// ----------------------------------------
`define QPM_RGN_COS      2'h0
`define QPM_RGN_DSCP     2'h1
`define QPM_RGN_PORT     2'h2
`define QPM_RGN_MISC     2'h3
`define QPM_MISC_SCHED   6'h00
`define QPM_MISC_CNT0    6'h04
`define QPM_PCFG_PRI_MSB   2
`define QPM_PCFG_PRI_LSB   0
`define QPM_PCFG_TRUST_MSB 4
`define QPM_PCFG_TRUST_LSB 3
`define QPM_SCHED_STRICT_BIT 0

// ----------------------------------------
// Reset values and header fields
// ----------------------------------------
`define QPM_DEF_PRI      3'h0
`define QPM_DEF_STRICT   1'h0
`define QPM_TOS_DSCP_MSB 7
`define QPM_TOS_DSCP_LSB 2
`define QPM_WEIGHT_Q3    4'h8
`define QPM_WEIGHT_Q2    4'h4
`define QPM_WEIGHT_Q1    4'h2
`define QPM_WEIGHT_Q0    4'h1

`endif

// File: core/qpm_pkg.sv
package qpm_pkg;
  // Queue number, 0 lowest .. 3 highest
  typedef logic [1:0] qpm_queue_t;
  // Trust mode as held in the port configuration word
  typedef enum logic [1:0] {
    tag_priority_only           = 2'h0,
    codepoint_only              = 2'h1,
    tag_priority_then_codepoint = 2'h2,
    codepoint_then_tag_priority = 2'h3
  } qpm_trust_t;
endpackage

// File: core/qpm_sched.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpm_params.svh"
module qpm_sched
  import qpm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       strict,
  input  wire logic       req,
  input  wire logic [3:0] nonempty,
  output var  logic       grant_valid,
  output var  qpm_queue_t grant_queue
);
  logic [3:0] credit [`QPM_NUM_QUEUES];
  logic [3:0] weight [`QPM_NUM_QUEUES];
  qpm_queue_t pick;
  logic       any;
  logic       reload;

  // ----------------------------------------
  // Pick: highest eligible queue
  // ----------------------------------------
  // Ascending loops leave the highest hit, so queue 3 wins
  always_comb begin
    logic       found;
    qpm_queue_t top_any;
    found   = 1'b0;
    any     = 1'b0;
    top_any = '0;
    pick    = '0;
    for (int i = 0; i < `QPM_NUM_QUEUES; i++) begin
      if (nonempty[i]) begin
        any     = 1'b1;
        top_any = qpm_queue_t'(i);
      end
      if (nonempty[i] && (strict || credit[i] != 4'h0)) begin
        found = 1'b1;
        pick  = qpm_queue_t'(i);
      end
    end
    // Round over: every waiting queue spent its share
    reload = any && !found && !strict;
    if (reload) begin
      pick = top_any;
    end
  end

  // ----------------------------------------
  // Per-queue credit, one generate lane each
  // ----------------------------------------
  for (genvar q = 0; q < `QPM_NUM_QUEUES; q++) begin : g_credit
    localparam logic [3:0] W = (q == 3) ? `QPM_WEIGHT_Q3 :
                               (q == 2) ? `QPM_WEIGHT_Q2 :
                               (q == 1) ? `QPM_WEIGHT_Q1 : `QPM_WEIGHT_Q0;
    assign weight[q] = W;
    // Credits frozen in strict mode so a switch back resumes the unfinished round
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        credit[q] <= W;
      end else if (req && any && !strict) begin
        if (reload) begin
          credit[q] <= (pick == qpm_queue_t'(q)) ? weight[q] - 4'h1 : weight[q];
        end else if (pick == qpm_queue_t'(q)) begin
          credit[q] <= credit[q] - 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Registered grant
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      grant_valid <= 1'b0;
      grant_queue <= '0;
    end else begin
      grant_valid <= req && any;
      grant_queue <= pick;
    end
  end
endmodule
`default_nettype wire

// File: core/qpm_top.sv
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "qpm_params.svh"
module qpm_top
  import qpm_pkg::*;
#(
  parameter int NPORTS = 8,
  parameter int PORT_W = 3
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [31:0]       reg_rdata,
  input  wire logic              frame_valid,
  input  wire logic [PORT_W-1:0] frame_port,
  input  wire logic              frame_tagged,
  input  wire logic              frame_prio_tagged,
  input  wire logic [2:0]        frame_tag_pri,
  input  wire logic              frame_ipv4,
  input  wire logic [7:0]        frame_tos,
  output var  logic              class_valid,
  output var  logic [PORT_W-1:0] class_port,
  output var  qpm_queue_t        class_queue,
  input  wire logic              sched_req,
  input  wire logic [3:0]        sched_nonempty,
  output var  logic              sched_grant_valid,
  output var  qpm_queue_t        sched_grant_queue
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (NPORTS < 1 || NPORTS > `QPM_MAX_PORTS || (1 << PORT_W) < NPORTS) begin : g_bad_param
    $error("qpm_top: NPORTS must be 1..64 and fit in PORT_W");
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  qpm_queue_t cos_table  [`QPM_NUM_COS];
  qpm_queue_t dscp_table [`QPM_NUM_DSCP];
  qpm_trust_t port_trust [NPORTS];
  logic [2:0] port_pri   [NPORTS];
  logic       strict;
  logic [15:0] q_count   [`QPM_NUM_QUEUES];

  // Reset content of the tag table
  function automatic qpm_queue_t cos_default(input int v);
    case (v)
      1, 2:    cos_default = 2'h0;
      0, 3:    cos_default = 2'h1;
      4, 5:    cos_default = 2'h2;
      default: cos_default = 2'h3;
    endcase
  endfunction

  // Reset content of the code point table
  function automatic qpm_queue_t dscp_default(input int v);
    if (v < 8)       dscp_default = 2'h1;
    else if (v < 24) dscp_default = 2'h0;
    else if (v < 32) dscp_default = 2'h1;
    else if (v < 48) dscp_default = 2'h2;
    else             dscp_default = 2'h3;
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [1:0] rgn;
  logic [5:0] idx;
  logic       hit_cos;
  logic       hit_port;
  assign rgn      = reg_addr[7:6];
  assign idx      = reg_addr[5:0];
  assign hit_cos  = (rgn == `QPM_RGN_COS) && (idx < 6'(`QPM_NUM_COS));
  assign hit_port = (rgn == `QPM_RGN_PORT) && (32'(idx) < NPORTS);

  // ----------------------------------------
  // Table writes
  // ----------------------------------------
  // A whole entry lands in one edge; lookup never sees half a write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `QPM_NUM_COS; i++) begin
        cos_table[i] <= cos_default(i);
      end
    end else if (reg_wr && hit_cos) begin
      cos_table[idx[2:0]] <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `QPM_NUM_DSCP; i++) begin
        dscp_table[i] <= dscp_default(i);
      end
    end else if (reg_wr && rgn == `QPM_RGN_DSCP) begin
      dscp_table[idx] <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------
  // Per-port configuration
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int p = 0; p < NPORTS; p++) begin
        port_trust[p] <= tag_priority_only;
        port_pri[p]   <= `QPM_DEF_PRI;
      end
    end else if (reg_wr && hit_port) begin
      port_trust[idx[PORT_W-1:0]] <=
        qpm_trust_t'(reg_wdata[`QPM_PCFG_TRUST_MSB:`QPM_PCFG_TRUST_LSB]);
      port_pri[idx[PORT_W-1:0]]   <= reg_wdata[`QPM_PCFG_PRI_MSB:`QPM_PCFG_PRI_LSB];
    end
  end

  // Scheduling discipline select
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strict <= `QPM_DEF_STRICT;
    end else if (reg_wr && rgn == `QPM_RGN_MISC && idx == `QPM_MISC_SCHED) begin
      strict <= reg_wdata[`QPM_SCHED_STRICT_BIT];
    end
  end

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  // Priority-tagged frames carry a tag but no usable class, like untagged
  logic        has_tag;
  logic [5:0]  codepoint;
  logic [2:0]  eff_pri;
  qpm_trust_t  trust;
  qpm_queue_t  q_tag;
  qpm_queue_t  q_cp;
  qpm_queue_t  q_def;
  qpm_queue_t  next_queue;

  assign has_tag   = frame_tagged && !frame_prio_tagged;
  assign codepoint = frame_tos[`QPM_TOS_DSCP_MSB:`QPM_TOS_DSCP_LSB];
  assign trust     = port_trust[frame_port];
  assign eff_pri   = has_tag ? frame_tag_pri : port_pri[frame_port];
  assign q_tag     = cos_table[eff_pri];
  assign q_cp      = dscp_table[codepoint];
  assign q_def     = cos_table[port_pri[frame_port]];

  // In the two combined modes missing fields fall back to the other table, then port default; single-table modes go straight to port default
  always_comb begin
    case (trust)
      tag_priority_only: begin
        next_queue = q_tag;
      end
      codepoint_only: begin
        next_queue = frame_ipv4 ? q_cp : q_def;
      end
      tag_priority_then_codepoint: begin
        next_queue = has_tag ? q_tag : (frame_ipv4 ? q_cp : q_def);
      end
      codepoint_then_tag_priority: begin
        next_queue = frame_ipv4 ? q_cp : q_tag;
      end
      default: begin
        next_queue = q_tag;
      end
    endcase
  end

  // One result per frame, one cycle after it is presented
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      class_valid <= 1'b0;
      class_port  <= '0;
      class_queue <= '0;
    end else begin
      class_valid <= frame_valid;
      class_port  <= frame_port;
      class_queue <= next_queue;
    end
  end

  // ----------------------------------------
  // Per-queue frame counters
  // ----------------------------------------
  // Counters wrap; software reads differences, so no clear is offered
  for (genvar q = 0; q < `QPM_NUM_QUEUES; q++) begin : g_cnt
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        q_count[q] <= '0;
      end else if (class_valid && class_queue == qpm_queue_t'(q)) begin
        q_count[q] <= q_count[q] + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Register read, data one cycle later
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      case (rgn)
        `QPM_RGN_COS: begin
          if (hit_cos) begin
            reg_rdata[1:0] <= cos_table[idx[2:0]];
          end
        end
        `QPM_RGN_DSCP: begin
          reg_rdata[1:0] <= dscp_table[idx];
        end
        `QPM_RGN_PORT: begin
          if (hit_port) begin
            reg_rdata[`QPM_PCFG_TRUST_MSB:`QPM_PCFG_TRUST_LSB] <= port_trust[idx[PORT_W-1:0]];
            reg_rdata[`QPM_PCFG_PRI_MSB:`QPM_PCFG_PRI_LSB]     <= port_pri[idx[PORT_W-1:0]];
          end
        end
        default: begin
          if (idx == `QPM_MISC_SCHED) begin
            reg_rdata[`QPM_SCHED_STRICT_BIT] <= strict;
          end else if (idx >= `QPM_MISC_CNT0 && idx < `QPM_MISC_CNT0 + 6'(`QPM_NUM_QUEUES)) begin
            reg_rdata[15:0] <= q_count[2'(idx - `QPM_MISC_CNT0)];
          end
        end
      endcase
    end else begin
      // Data stand only in the cycle after the read
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------
  // Egress scheduler
  // ----------------------------------------
  qpm_sched u_sched (
    .mclk        (mclk),
    .resetn      (resetn),
    .strict      (strict),
    .req         (sched_req),
    .nonempty    (sched_nonempty),
    .grant_valid (sched_grant_valid),
    .grant_queue (sched_grant_queue)
  );

endmodule
`default_nettype wire

// File: dv/qpm_properties.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// Port-level checks
// --------------------
module qpm_props
  import qpm_pkg::*;
#(
  parameter int PORT_W = 3
) (
  input wire logic              mclk,
  input wire logic              resetn,
  input wire logic [7:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              frame_valid,
  input wire logic [PORT_W-1:0] frame_port,
  input wire logic              frame_tagged,
  input wire logic              frame_prio_tagged,
  input wire logic [2:0]        frame_tag_pri,
  input wire logic              frame_ipv4,
  input wire logic [7:0]        frame_tos,
  input wire logic              class_valid,
  input wire logic [PORT_W-1:0] class_port,
  input wire qpm_queue_t        class_queue,
  input wire logic              sched_req,
  input wire logic [3:0]        sched_nonempty,
  input wire logic              sched_grant_valid,
  input wire qpm_queue_t        sched_grant_queue
);
  logic       strict;
  logic       touched;
  logic [3:0] ne_q;
  // Mode mirror; defaults only hold until the first write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strict  <= 1'h0;
      touched <= 1'h0;
      ne_q    <= 4'h0;
    end else begin
      ne_q <= sched_nonempty;
      if (reg_wr) touched <= 1'h1;
      if (reg_wr && reg_addr == 8'hC0) strict <= reg_wdata[0];
    end
  end
  function automatic qpm_queue_t cos_def(logic [2:0] p);
    case (p)
      3'h1, 3'h2: return 2'h0;
      3'h0, 3'h3: return 2'h1;
      3'h4, 3'h5: return 2'h2;
      default:    return 2'h3;
    endcase
  endfunction
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_frame;
    frame_valid;
  endsequence
  sequence s_pick;
    sched_req && sched_nonempty != 4'h0;
  endsequence
  cls_pulse_a: assert property (s_frame |=> class_valid)
    else $error("class result missing");
  cls_idle_a: assert property (!frame_valid |=> !class_valid)
    else $error("class result without frame");
  cls_port_a: assert property (s_frame |=> class_port == $past(frame_port))
    else $error("class port wrong");
  cls_default_a: assert property (frame_valid && !touched && frame_tagged && !frame_prio_tagged
    |=> class_queue == cos_def($past(frame_tag_pri))) else $error("default tag map wrong");
  cls_untag_a: assert property (frame_valid && !touched && !(frame_tagged && !frame_prio_tagged)
    |=> class_queue == 2'h1) else $error("untagged default wrong");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  rd_field_a: assert property (reg_rd && reg_addr < 8'h80 |=> reg_rdata[31:2] == 30'h0)
    else $error("table entry upper bits set");
  grant_strict_a: assert property (strict and s_pick
    |=> sched_grant_valid && sched_grant_queue == (ne_q[3] ? 2'h3 : ne_q[2] ? 2'h2 : ne_q[1] ? 2'h1 : 2'h0))
    else $error("strict pick wrong");
  grant_none_a: assert property (!(sched_req && sched_nonempty != 4'h0) |=> !sched_grant_valid)
    else $error("grant without request");
  grant_member_a: assert property (s_pick |=> sched_grant_valid && ne_q[sched_grant_queue])
    else $error("grant to empty queue");
endmodule
bind qpm_top qpm_props #(.PORT_W(PORT_W)) props_u (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .frame_valid, .frame_port, .frame_tagged, .frame_prio_tagged, .frame_tag_pri,
  .frame_ipv4, .frame_tos, .class_valid, .class_port, .class_queue, .sched_req, .sched_nonempty,
  .sched_grant_valid, .sched_grant_queue);
`default_nettype wire

// File: dv/qpm_partner.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// Egress scheduler side
// --------------------
module qpm_egress_model (
  input  wire logic       mclk,
  input  wire logic       run,
  input  wire logic [7:0] rnd,
  output var  logic       sched_req,
  output var  logic [3:0] sched_nonempty
);
  // Quiet until the first edge
  initial begin
    sched_req = 1'h0;
    sched_nonempty = 4'h0;
  end
  // Stalls at random; all-full often so the weights show
  always @(posedge mclk) begin
    sched_req <= run && (rnd[0] || rnd[1]);
    sched_nonempty <= rnd[7] ? 4'hF : rnd[6:3];
  end
endmodule
`default_nettype wire

// File: dv/qpm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// Bench
// --------------------
module qpm_top_tb;
  import qpm_pkg::*;
  logic        mclk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, run = 1'h0;
  logic        frame_valid = 1'h0, frame_tagged = 1'h0, frame_prio_tagged = 1'h0, frame_ipv4 = 1'h0;
  logic        class_valid, sched_req, sched_grant_valid;
  logic [7:0]  reg_addr = 8'h0, frame_tos = 8'h0, r = 8'h38, pr = 8'h38, a, b;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [2:0]  frame_port = 3'h0, frame_tag_pri = 3'h0, class_port;
  logic [3:0]  sched_nonempty;
  qpm_queue_t  class_queue, sched_grant_queue;
  int          cos_t[8] = '{1, 0, 0, 1, 2, 2, 3, 3}, dscp_t[64], ppri[8], ptr[8], cnt[4];
  int          cred[4] = '{1, 2, 4, 8}, qc[$], qg[$], qp[$], error_cnt, num_checks;
  bit          strict_m, ph;
  qpm_top dut_u (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_valid,
    .frame_port, .frame_tagged, .frame_prio_tagged, .frame_tag_pri, .frame_ipv4, .frame_tos, .class_valid,
    .class_port, .class_queue, .sched_req, .sched_nonempty, .sched_grant_valid, .sched_grant_queue);
  qpm_egress_model eg_u (.mclk, .run, .rnd(pr), .sched_req, .sched_nonempty);
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Reference choice of queue for one frame
  function automatic int cls(int p, bit t, bit pt, int tp, bit v4, int cp);
    bit h;
    h = t && !pt;
    case (ptr[p])
      0: return cos_t[h ? tp : ppri[p]];
      1: return v4 ? dscp_t[cp] : cos_t[ppri[p]];
      2: return h ? cos_t[tp] : v4 ? dscp_t[cp] : cos_t[ppri[p]];
      default: return v4 ? dscp_t[cp] : cos_t[h ? tp : ppri[p]];
    endcase
  endfunction
  // Reference pick; credits frozen in strict mode
  function automatic int pick(logic [3:0] n);
    int h;
    h = n[3] ? 3 : n[2] ? 2 : n[1] ? 1 : 0;
    if (strict_m) return h;
    for (int q = 3; q >= 0; q--) if (n[q] && cred[q] > 0) begin
      cred[q]--;
      return q;
    end
    cred = '{1, 2, 4, 8};
    cred[h]--;
    return h;
  endfunction
  task automatic chk_reg(int exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected reg_rdata exp %0d got %0d", exp, got);
    end
  endtask
  task automatic chk_q(string what, int exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s exp %0d got %0d", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
    // Model moves at the taking edge; mode by NBA so this edge's pick keeps the old one
    if (ad < 8) cos_t[ad] = d[1:0];
    else if (ad >= 8'h40 && ad < 8'h80) dscp_t[ad - 8'h40] = d[1:0];
    else if (ad >= 8'h80 && ad < 8'h88) begin
      ptr[ad[2:0]] = d[4:3];
      ppri[ad[2:0]] = d[2:0];
    end else if (ad == 8'hC0) strict_m <= d[0];
  endtask
  task automatic rd(logic [7:0] ad, int exp);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(negedge mclk);
    chk_reg(exp, reg_rdata);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Clock, and the partner's own random stream
  initial forever #50 mclk = ~mclk;
  always @(negedge mclk) pr <= lfsr(pr);
  // Grants predicted at the request edge, before the partner moves
  always @(posedge mclk) if (resetn && sched_req && sched_nonempty != 4'h0) qg.push_back(pick(sched_nonempty));
  // Results checked mid-cycle; a stray result finds an empty queue and fails
  always @(negedge mclk) if (resetn) begin
    if (class_valid) chk_q("class_queue", qc.size() ? qc.pop_front() : 4, class_queue);
    if (class_valid) chk_q("class_port", qp.size() ? qp.pop_front() : 8, class_port);
    if (sched_grant_valid) chk_q("grant_queue", qg.size() ? qg.pop_front() : 4, sched_grant_queue);
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 64; i++) dscp_t[i] = i < 8 ? 1 : i < 24 ? 0 : i < 32 ? 1 : i < 48 ? 2 : 3;
    repeat (8) @(posedge mclk);
    resetn <= 1'h1;
    run <= 1'h1;
    for (int i = 0; i < 8; i++) rd(i, cos_t[i]);
    for (int i = 0; i < 64; i++) rd(8'h40 + i, dscp_t[i]);
    rd(8'h85, 0);
    rd(8'h10, 0);
    for (int ps = 0; ps < 2; ps++) begin
      for (int i = 0; i < 300; i++) begin
        @(posedge mclk);
        r = lfsr(r);
        a = r;
        r = lfsr(r);
        b = r;
        frame_valid <= a[0];
        frame_port <= a[3:1];
        frame_tagged <= a[4];
        frame_prio_tagged <= a[5] & a[6];
        frame_tag_pri <= b[2:0];
        frame_ipv4 <= a[7];
        frame_tos <= b;
        reg_wr <= b[3] & ph;
        reg_addr <= {5'h0, a[3:1]};
        reg_wdata <= {24'h0, b};
        if (a[0]) qc.push_back(cls(a[3:1], a[4], a[5] & a[6], b[2:0], a[7], b[7:2]));
        if (a[0]) cnt[qc[$]]++;
        if (a[0]) qp.push_back(a[3:1]);
        if (b[3] & ph) cos_t[a[3:1]] = b[1:0];
      end
      @(posedge mclk);
      frame_valid <= 1'h0;
      reg_wr <= 1'h0;
      if (ps == 0) begin
        // Trust mode from the port number so all four modes are exercised
        for (int p = 0; p < 8; p++) begin
          r = lfsr(r);
          wr(8'h80 + p, {27'h0, p[1:0], r[2:0]});
        end
        for (int i = 0; i < 64; i++) wr(8'h40 + i, lfsr(i));
        wr(8'h20, 32'h3);
        wr(8'hC4, 32'h5);
        run <= 1'h0;
        wr(8'hC0, 32'h1);
        run <= 1'h1;
        repeat (150) @(posedge mclk);
        run <= 1'h0;
        wr(8'hC0, 32'h0);
        run <= 1'h1;
        ph = 1'b1;
      end
    end
    run <= 1'h0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 8; i++) rd(8'h80 + i, ptr[i] * 8 + ppri[i]);
    for (int i = 0; i < 8; i++) rd(i, cos_t[i]);
    for (int i = 0; i < 64; i += 9) rd(8'h40 + i, dscp_t[i]);
    for (int q = 0; q < 4; q++) rd(8'hC4 + q, cnt[q]);
    rd(8'h20, 0);
    for (int k = 0; k < 20 && (qc.size() || qg.size()); k++) @(posedge mclk);
    if (qc.size() || qg.size()) error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
